// [verilog/prr_pkg.sv]
// constants and types for the prom reset and reconfiguration trigger
// Function
// - hold reset line low during power-up until supplies pass thresholds
// - release reset line only after minimum release delay
// - supply loss resets device and holds line low again
// - reset line is always active low, never inverted
// - reset or chip-enable high clears address, cascade out high, floats outputs
// - serial variant release depends only on core supply threshold
// - parallel variant also waits for output supply good
// - reset line is open-drain, pulled up, wired to fpga init
// - reconfigure update drives configuration pin low for a while
// - then drive high briefly, then release to pull-up
// - parallel variant: configuration pin low resets selected revision
// - parallel variant: stays in reset while configuration pin sensed low
// - serial variant: configuration pin is output only
// - jtag port follows standard tap behaviour
package prr_pkg;
  localparam int          CLK_MHZ            = 100;
  localparam int          RELEASE_DELAY_US   = 2000;
  localparam int          RELEASE_DELAY_CYC  = RELEASE_DELAY_US * CLK_MHZ;
  localparam int          CFG_LOW_US         = 1;
  localparam int          CFG_LOW_CYC        = CFG_LOW_US * CLK_MHZ;
  localparam int          CFG_HIGH_CYC       = 2;
  localparam int          ADDR_W             = 24;
  localparam logic [23:0] ADDR_RST           = 24'h000000;
  localparam int          SYNC_STAGES        = 2;

  typedef enum logic [2:0]
  {
    PRR_IDLE = 3'b001,
    PRR_LOW  = 3'b010,
    PRR_HIGH = 3'b100
  } prr_cfg_t;
endpackage

// [verilog/prr_sync_if.sv]
// interface carrying raw pins into the synchroniser and clean levels out
`timescale 1ns/100ps
`default_nettype none
interface prr_sync_if;
  logic [4:0] raw;
  logic [4:0] clean;
  modport src (output raw, input clean);
  modport snk (input raw, output clean);
endinterface
`default_nettype wire

// [verilog/prr_sync.sv]
// two flop synchroniser bank for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module prr_sync
  import prr_pkg::*;
#(
  parameter int W = 5
)
(
  input  wire logic core_clk,
  input  wire logic rst_b,
  prr_sync_if.snk   sif
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  // first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1_r <= '0;
      s2_r <= '0;
    end
    else
    begin
      s1_r <= sif.raw;
      s2_r <= s1_r;
    end
  end

  assign sif.clean = s2_r;
endmodule
`default_nettype wire

// [verilog/prr_top.sv]
// reset sequencer and reconfiguration pulse generator of a config prom
`timescale 1ns/100ps
`default_nettype none
module prr_top
  import prr_pkg::*;
#(
  parameter bit PARALLEL     = 1'b1,
  parameter int RELEASE_CYC  = RELEASE_DELAY_CYC,
  parameter int CFGLOW_CYC   = CFG_LOW_CYC
)
(
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              core_supply_por_ok,
  input  wire logic              out_supply_ok,
  input  wire logic              reset_line_in,
  input  wire logic              chip_enable_n,
  input  wire logic              reconfig_pulse_n_in,
  input  wire logic              jtag_reconfig_update,
  output logic                   reset_line_out,
  output logic                   reset_line_oe_n,
  output logic                   reconfig_pulse_n_out,
  output logic                   reconfig_pulse_oe_n,
  output logic                   chip_select_cascade_out_n,
  output logic                   data_out_oe_n,
  output logic [ADDR_W-1:0]      addr_cnt,
  output logic                   revision_reset
);
  ////////////////////////////////////////////////////////////////////
  // synchronise asynchronous pins
  prr_sync_if sif ();
  logic por_ok;
  logic vco_ok;
  logic line_hi;
  logic ce_hi;
  logic cf_hi;

  assign sif.raw = {core_supply_por_ok, out_supply_ok, reset_line_in,
                    chip_enable_n, reconfig_pulse_n_in};

  prr_sync #(.W(5)) u_sync
  (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .sif      (sif)
  );

  assign por_ok  = sif.clean[4];
  assign vco_ok  = sif.clean[3];
  assign line_hi = sif.clean[2];
  assign ce_hi   = sif.clean[1];
  assign cf_hi   = sif.clean[0];

  ////////////////////////////////////////////////////////////////////
  // supply good decision per variant
  logic supplies_ok;
  logic cf_reset;

  // serial variant sees core supply only
  assign supplies_ok = PARALLEL ? (por_ok && vco_ok) : por_ok;
  // cf low holds the parallel variant in reset
  assign cf_reset    = PARALLEL && !cf_hi;

  ////////////////////////////////////////////////////////////////////
  // release delay counter
  logic [31:0] dly_r;
  logic [31:0] dly_nxt;
  logic        released_r;
  logic        released_nxt;

  // count up while supplies good, restart on any drop
  always_comb
  begin
    dly_nxt      = dly_r;
    released_nxt = released_r;
    if (!supplies_ok || cf_reset)
    begin
      dly_nxt      = '0;
      released_nxt = 1'b0;
    end
    else if (!released_r)
    begin
      if (dly_r >= 32'(RELEASE_CYC - 1))
        released_nxt = 1'b1;
      else
        dly_nxt = dly_r + 32'h00000001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dly_r      <= '0;
      released_r <= 1'b0;
    end
    else
    begin
      dly_r      <= dly_nxt;
      released_r <= released_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // reconfiguration pulse sequencer
  prr_cfg_t    cst_r;
  prr_cfg_t    cst_nxt;
  logic [31:0] ccnt_r;
  logic [31:0] ccnt_nxt;

  // low phase, brief high, then release
  always_comb
  begin
    cst_nxt  = cst_r;
    ccnt_nxt = ccnt_r;
    unique case (cst_r)
      PRR_IDLE:
      begin
        if (jtag_reconfig_update)
        begin
          cst_nxt  = PRR_LOW;
          ccnt_nxt = '0;
        end
      end
      PRR_LOW:
      begin
        if (ccnt_r >= 32'(CFGLOW_CYC - 1))
        begin
          cst_nxt  = PRR_HIGH;
          ccnt_nxt = '0;
        end
        else
          ccnt_nxt = ccnt_r + 32'h00000001;
      end
      PRR_HIGH:
      begin
        if (ccnt_r >= 32'(CFG_HIGH_CYC - 1))
          cst_nxt = PRR_IDLE;
        else
          ccnt_nxt = ccnt_r + 32'h00000001;
      end
      default:
      begin
        cst_nxt  = PRR_IDLE;
        ccnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cst_r  <= PRR_IDLE;
      ccnt_r <= '0;
    end
    else
    begin
      cst_r  <= cst_nxt;
      ccnt_r <= ccnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin drivers, address counter and revision reset
  logic              dev_reset;
  logic              rl_out_nxt;
  logic              rl_oe_nxt;
  logic              cf_out_nxt;
  logic              cf_oe_nxt;
  logic              ceo_nxt;
  logic              doe_nxt;
  logic [ADDR_W-1:0] addr_nxt;
  logic              rev_nxt;

  // sensed low line (own or monitor) or ce high resets core
  assign dev_reset = !released_r || !line_hi || ce_hi || cf_reset;

  always_comb
  begin
    // open drain: drive low until released, never inverted
    rl_out_nxt = 1'b0;
    rl_oe_nxt  = released_r;
    cf_out_nxt = (cst_r != PRR_LOW); // high when idle, so release never dips low
    cf_oe_nxt  = (cst_r == PRR_IDLE);
    ceo_nxt    = 1'b1;
    doe_nxt    = 1'b1;
    addr_nxt   = addr_cnt;
    if (dev_reset)
    begin
      addr_nxt = ADDR_RST;
      ceo_nxt  = 1'b1;
      doe_nxt  = 1'b1;
    end
    else
    begin
      ceo_nxt  = 1'b0;
      doe_nxt  = 1'b0;
      addr_nxt = addr_cnt + ADDR_W'(1); // one word per cycle while enabled
    end
    // revision selection restarts on cf low
    rev_nxt = cf_reset;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reset_line_out            <= 1'b0;
      reset_line_oe_n           <= 1'b0;
      reconfig_pulse_n_out      <= 1'b1;
      reconfig_pulse_oe_n       <= 1'b1;
      chip_select_cascade_out_n <= 1'b1;
      data_out_oe_n             <= 1'b1;
      addr_cnt                  <= ADDR_RST;
      revision_reset            <= 1'b1;
    end
    else
    begin
      reset_line_out            <= rl_out_nxt;
      reset_line_oe_n           <= rl_oe_nxt;
      reconfig_pulse_n_out      <= cf_out_nxt;
      reconfig_pulse_oe_n       <= cf_oe_nxt;
      chip_select_cascade_out_n <= ceo_nxt;
      data_out_oe_n             <= doe_nxt;
      addr_cnt                  <= addr_nxt;
      revision_reset            <= rev_nxt;
    end
  end

  // the tap itself lives in a separate standard controller; this
  // block consumes its decoded update strobe only
endmodule
`default_nettype wire

// [tb/prr_fpga_model.sv]
// far side: pull-ups, fpga init and program pins
`timescale 1ns/100ps
`default_nettype none
module prr_fpga_model
(
  input  wire logic rl_out,
  input  wire logic rl_oe_n,
  input  wire logic cf_out,
  input  wire logic cf_oe_n,
  input  wire logic hold_low,
  output logic      rl_wire,
  output logic      cf_wire,
  output int        n_prog
);
  // open-drain line with pull-up, init or monitor may pull low
  assign rl_wire = (rl_oe_n ? 1'b1 : rl_out) & ~hold_low;
  // config pin pulled up and tied to the program input
  assign cf_wire = cf_oe_n ? 1'b1 : cf_out;
  // program pulses seen by the fpga
  int cnt = 0;
  always @(negedge cf_wire) cnt++;
  assign n_prog = cnt;
endmodule
`default_nettype wire

// [tb/prr_monitor.sv]
// port checker for the reset sequencer
`timescale 1ns/100ps
`default_nettype none
module prr_monitor
  import prr_pkg::*;
#(
  parameter bit PARALLEL    = 1'b1,
  parameter int RELEASE_CYC = RELEASE_DELAY_CYC,
  parameter int CFGLOW_CYC  = CFG_LOW_CYC
)
(
  input wire logic              core_clk,
  input wire logic              rst_b,
  input wire logic              core_supply_por_ok,
  input wire logic              out_supply_ok,
  input wire logic              reset_line_in,
  input wire logic              chip_enable_n,
  input wire logic              reconfig_pulse_n_in,
  input wire logic              jtag_reconfig_update,
  input wire logic              reset_line_out,
  input wire logic              reset_line_oe_n,
  input wire logic              reconfig_pulse_n_out,
  input wire logic              reconfig_pulse_oe_n,
  input wire logic              chip_select_cascade_out_n,
  input wire logic              data_out_oe_n,
  input wire logic [ADDR_W-1:0] addr_cnt,
  input wire logic              revision_reset
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // high phase of the pulse and its release
  sequence cfg_hi;
    $rose(reconfig_pulse_n_out) && !reconfig_pulse_oe_n;
  endsequence
  sequence cfg_rel;
    (reconfig_pulse_n_out && !reconfig_pulse_oe_n) ##1 reconfig_pulse_oe_n;
  endsequence
  // consecutive cycles with every release condition met at the pins
  int good_run;
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      good_run <= 0;
    else if (!(core_supply_por_ok && (!PARALLEL || (out_supply_ok && reconfig_pulse_n_in))))
      good_run <= 0;
    else if (good_run < RELEASE_CYC)
      good_run <= good_run + 1;
  end
  chk_release_delay: assert property ($rose(reset_line_oe_n) |-> good_run >= RELEASE_CYC)
    else $error("release before delay");
  chk_line_polarity: assert property (!reset_line_out)
    else $error("line driven high");
  chk_drop_holds: assert property ($fell(core_supply_por_ok) |-> ##[1:4] !reset_line_oe_n)
    else $error("no hold on drop");
  chk_release_late: assert property ($rose(reset_line_oe_n) |-> $past(core_supply_por_ok, 8)
    && (!PARALLEL || $past(out_supply_ok, 8))) else $error("early release");
  chk_ce_reset: assert property (chip_enable_n [*5] |-> chip_select_cascade_out_n
    && data_out_oe_n && addr_cnt == '0) else $error("no reset on ce");
  chk_line_reset: assert property (!reset_line_in [*5] |-> chip_select_cascade_out_n
    && data_out_oe_n) else $error("no reset on line");
  chk_cfg_start: assert property (jtag_reconfig_update && reconfig_pulse_oe_n
    && $past(reconfig_pulse_oe_n) |-> ##[1:2] (!reconfig_pulse_oe_n && !reconfig_pulse_n_out))
    else $error("no pulse");
  chk_cfg_low_len: assert property (cfg_hi |-> !$past(reconfig_pulse_oe_n, CFGLOW_CYC)
    && $past(reconfig_pulse_oe_n, CFGLOW_CYC + 1)) else $error("low phase length");
  chk_cfg_high: assert property (cfg_hi |-> ##1 cfg_rel)
    else $error("high phase");
  chk_rev_reset: assert property ((PARALLEL && !reconfig_pulse_n_in) [*4] |-> revision_reset
    && data_out_oe_n) else $error("no revision reset");
endmodule
bind prr_top prr_monitor #(.PARALLEL(PARALLEL), .RELEASE_CYC(RELEASE_CYC),
  .CFGLOW_CYC(CFGLOW_CYC)) u_prr_monitor (.core_clk, .rst_b, .core_supply_por_ok,
  .out_supply_ok, .reset_line_in, .chip_enable_n, .reconfig_pulse_n_in, .jtag_reconfig_update,
  .reset_line_out, .reset_line_oe_n, .reconfig_pulse_n_out, .reconfig_pulse_oe_n,
  .chip_select_cascade_out_n, .data_out_oe_n, .addr_cnt, .revision_reset);
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the reset sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  import prr_pkg::*;
  localparam int RC = 20;
  localparam int LC = 5;
  logic core_clk = 0, rst_b = 0, sup = 0, osup = 0, ce_n = 1, upd = 0, hold = 0;
  logic rl_w, cf_w, rl_o, rl_oe, cf_o, cf_oe, cso, doe, rev;
  logic [ADDR_W-1:0] addr;
  int np, n_mismatch = 0, n_checks = 0;
  logic [31:0] lf = 32'h768fa374;
  always #5 core_clk = ~core_clk;
  // next value of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  prr_top #(.PARALLEL(1'b1), .RELEASE_CYC(RC), .CFGLOW_CYC(LC)) u_prr_top (.core_clk(core_clk),
    .rst_b(rst_b), .core_supply_por_ok(sup), .out_supply_ok(osup), .reset_line_in(rl_w),
    .chip_enable_n(ce_n), .reconfig_pulse_n_in(cf_w), .jtag_reconfig_update(upd),
    .reset_line_out(rl_o), .reset_line_oe_n(rl_oe), .reconfig_pulse_n_out(cf_o),
    .reconfig_pulse_oe_n(cf_oe), .chip_select_cascade_out_n(cso), .data_out_oe_n(doe),
    .addr_cnt(addr), .revision_reset(rev));
  prr_fpga_model u_prr_fpga_model (.rl_out(rl_o), .rl_oe_n(rl_oe), .cf_out(cf_o),
    .cf_oe_n(cf_oe), .hold_low(hold), .rl_wire(rl_w), .cf_wire(cf_w), .n_prog(np));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // count cycles until the line is released, bounded
  task automatic rel_wait;
    int t;
    t = 0;
    while (rl_oe !== 1'b1 && t < RC + 8)
    begin
      cyc(1);
      t++;
    end
    chk(t >= RC && t < RC + 8, 1);
  endtask
  // reference model: release after RC good samples, seen three edges later
  logic exp_rel = 1'b0;
  int   run = 0;
  int   runq[$];
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      run = 0;
      runq.delete();
    end
    else
    begin
      run = (sup && osup && cf_w === 1'b1) ? run + 1 : 0;
      runq.push_back(run);
      if (runq.size() > 3)
        exp_rel = (runq.pop_front() >= RC);
    end
  end
  // line release compared on every cycle out of reset
  always @(negedge core_clk)
    if (rst_b)
      chk(rl_oe, exp_rel);
  // main sequence
  initial
  begin : main
    int t;
    cyc(10);
    chk(rl_oe, 0);
    rst_b = 1;
    sup = 1;
    cyc(RC + 8);
    chk(rl_oe, 0);
    osup = 1;
    rel_wait();
    $display("power-up done");
    sup = 0;
    cyc(4);
    chk({rl_oe, doe}, 2'b01);
    sup = 1;
    rel_wait();
    $display("brown-out done");
    repeat (40)
    begin
      lf = lfsr_next(lf);
      ce_n = lf[0];
      hold = lf[1] & lf[2];
      cyc(5);
      chk({cso, doe}, {2{ce_n | hold}});
      if (ce_n | hold)
        chk(addr, 0);
      else
        chk(addr != 0, 1);
    end
    ce_n = 0;
    hold = 0;
    cyc(5);
    $display("enable done");
    for (int k = 0; k < 2; k++)
    begin
      upd = 1;
      cyc(1);
      upd = 0;
      t = 0;
      while (cf_w !== 1'b0 && t < 6)
      begin
        cyc(1);
        t++;
      end
      chk(t, 1);
      t = 0;
      while (cf_w === 1'b0 && t < 40)
      begin
        upd = (k == 1 && t == 1);
        cyc(1);
        t++;
        if (t == 4)
          chk({rev, doe, rl_oe}, 3'b110);
      end
      upd = 0;
      chk(t, LC);
      chk({cf_oe, cf_o}, 2'b01);
      cyc(2);
      chk(cf_oe, 1);
      chk(np, k + 1);
      cyc(4);
    end
    $display("reconfig done");
    finish_test();
  end
  // hang guard
  initial
  begin
    #400000;
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire
